// ===== src/ssp_params.svh
// Summary of operation
// - Buffer write during SPI transfer sets write collision.
// - SPI slave byte into full buffer sets overflow, dropped.
// - Overflow is never set in master operation.
// - Master transfer starts only on buffer write.
// - Enable bit hands pins to port.
// - Polarity bit sets serial clock idle level.
// - Codes 0000, 0001, 0010, 0011 pick master clocks.
// - Codes 0100/0101 slave with/without select gating.
// - Matching write address loads into buffer.
// - Unread address overflows on next byte.
// - Interrupt flag raised once per received byte.
// - Each I2C byte updates full, direction, data/address bits.
// - Byte into full buffer: overflow, no acknowledge.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define SSP_CTRL_OFS 12'h000
`define SSP_BUF_OFS 12'h004
`define SSP_STAT_OFS 12'h008
`define SSP_ISTAT_OFS 12'h00c
`define SSP_IMASK_OFS 12'h010
`define SSP_OWN_OFS 12'h014

// ****************************************
// Field positions
// ****************************************
`define SSP_WRITE_COLLISION_FLAG_BIT 7
`define SSP_OVF_BIT 6
`define SSP_EN_BIT 5
`define SSP_CKP_BIT 4
`define SSP_ST_BF_BIT 0
`define SSP_ST_RW_BIT 1
`define SSP_ST_DA_BIT 2
`define SSP_IRQ_BYTE_BIT 0
`define SSP_IRQ_WRITE_COLLISION_FLAG_BIT 1
`define SSP_IRQ_OVF_BIT 2

// ****************************************
// Reset values and timing counts
// ****************************************
`define SSP_CTRL_RST 8'h00
`define SSP_OWN_RST 7'h00
`define SSP_IMASK_RST 3'h0
`define SSP_HALF_DIV4 6'd2
`define SSP_HALF_DIV16 6'd8
`define SSP_HALF_DIV64 6'd32

`endif

// ===== src/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [3:0] {
    SSP_M_DIV4 = 4'h0,
    SSP_M_DIV16 = 4'h1,
    SSP_M_DIV64 = 4'h2,
    SSP_M_TIMER_TWO_COUNT = 4'h3,
    SSP_M_SLV_SS = 4'h4,
    SSP_M_SLV_NOSS = 4'h5,
    SSP_M_I2C_SLV = 4'h6
  } ssp_mode_e;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'b0001,
    I2C_ADDR = 4'b0010,
    I2C_DATA = 4'b0100,
    I2C_ACK = 4'b1000
  } ssp_i2c_e;
endpackage : ssp_pkg

// ===== src/ssp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule : ssp_sync
`default_nettype wire

// ===== src/ssp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top
  import ssp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE,
  input wire logic SDI_IN,
  output logic SDO_OUT,
  output logic SDO_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SS_N_IN,
  output logic SS_OWNED,
  input wire logic TIMER_TWO_OUT
);
  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic is_master(input logic [3:0] m);
    return m[3:2] == 2'b00;
  endfunction : is_master

  function automatic logic is_spi_slave(input logic [3:0] m);
    return (m == SSP_M_SLV_SS) || (m == SSP_M_SLV_NOSS);
  endfunction : is_spi_slave

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : addr_is

  logic [7:0] port_control_reg;
  logic [7:0] shift_buffer;
  logic [7:0] shift_register;
  logic [7:0] i2c_sr;
  logic [6:0] own_addr;
  logic [2:0] ists;
  logic [2:0] imask;
  logic buffer_full_flag;
  logic st_rw;
  logic st_da;
  logic en;
  logic clock_idle_polarity;
  logic [3:0] mode;
  logic [3:0] s_q;
  logic [3:0] s_d;
  logic sck_s;
  logic sdi_s;
  logic ss_n_s;
  logic tmr_s;

  assign en = port_control_reg[`SSP_EN_BIT];
  assign clock_idle_polarity = port_control_reg[`SSP_CKP_BIT];
  assign mode = port_control_reg[3:0];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  ssp_sync #(.W(4)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d({TIMER_TWO_OUT, SS_N_IN, SDI_IN, SCK_IN}),
    .q(s_q)
  );

  assign {tmr_s, ss_n_s, sdi_s, sck_s} = s_q;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_d <= 4'h0;
    end else begin
      s_d <= s_q;
    end
  end

  // ****************************************
  // APB access decode
  // ****************************************
  logic acc;
  logic wr;
  logic rd;
  logic wr_buf;
  logic rd_buf;
  logic hit;
  logic [31:0] rdata;

  assign acc = PSEL & PENABLE & PREADY;
  assign wr = acc & PWRITE;
  assign rd = acc & ~PWRITE;
  assign wr_buf = wr & addr_is(PADDR, `SSP_BUF_OFS);
  assign rd_buf = rd & addr_is(PADDR, `SSP_BUF_OFS);

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    unique case (PADDR)
      `SSP_CTRL_OFS: rdata[7:0] = port_control_reg;
      `SSP_BUF_OFS: rdata[7:0] = shift_buffer;
      `SSP_STAT_OFS: rdata[2:0] = {st_da, st_rw, buffer_full_flag};
      `SSP_ISTAT_OFS: rdata[2:0] = ists;
      `SSP_IMASK_OFS: rdata[2:0] = imask;
      `SSP_OWN_OFS: rdata[6:0] = own_addr;
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, so every access has no wait state.
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PREADY <= 1'b1;
      PRDATA <= rdata;
      PSLVERR <= ~hit;
    end else if (acc) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // ****************************************
  // SPI clocking and shifting
  // ****************************************
  logic [5:0] half;
  logic [5:0] div_cnt;
  logic tick;
  logic busy;
  logic [3:0] phase;
  logic samp;
  logic sck_q;
  logic sdo_q;
  logic spi_done;
  logic xfer_busy;
  logic slv_sel;
  logic lead;
  logic trail;
  logic spi_ovf;

  always_comb begin
    unique case (mode)
      SSP_M_DIV16: half = `SSP_HALF_DIV16;
      SSP_M_DIV64: half = `SSP_HALF_DIV64;
      default: half = `SSP_HALF_DIV4;
    endcase
  end

  // Timer mode toggles on each rising timer output edge, halving its rate.
  assign tick = (mode == SSP_M_TIMER_TWO_COUNT) ? (tmr_s & ~s_d[3]) : (div_cnt == half - 6'd1);
  assign slv_sel = (mode == SSP_M_SLV_NOSS) | ~ss_n_s;
  assign xfer_busy = is_master(mode) ? busy : (phase != 4'h0);

  always_comb begin
    lead = 1'b0;
    trail = 1'b0;
    if (is_master(mode)) begin
      lead = busy & tick & ~phase[0];
      trail = busy & tick & phase[0];
    end else if (is_spi_slave(mode) && slv_sel) begin
      lead = (sck_s != s_d[0]) & (sck_s != clock_idle_polarity);
      trail = (sck_s != s_d[0]) & (sck_s == clock_idle_polarity);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt <= 6'h0;
    end else if (!busy || tick) begin
      div_cnt <= 6'h0;
    end else begin
      div_cnt <= div_cnt + 6'd1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy <= 1'b0;
      phase <= 4'h0;
      samp <= 1'b0;
      sck_q <= 1'b0;
      sdo_q <= 1'b0;
      shift_register <= 8'h0;
      spi_done <= 1'b0;
    end else begin
      spi_done <= 1'b0;
      if (!en || (is_spi_slave(mode) && !slv_sel)) begin
        busy <= 1'b0;
        phase <= 4'h0;
        sck_q <= clock_idle_polarity;
      end else if (wr_buf && !xfer_busy) begin
        shift_register <= PWDATA[7:0];
        sdo_q <= PWDATA[7];
        busy <= is_master(mode);
        phase <= 4'h0;
        sck_q <= clock_idle_polarity;
      end else if (lead) begin
        samp <= sdi_s;
        phase <= phase + 4'd1;
        sck_q <= ~sck_q;
      end else if (trail) begin
        shift_register <= {shift_register[6:0], samp};
        sdo_q <= shift_register[6];
        phase <= phase + 4'd1;
        sck_q <= ~sck_q;
        if (phase == 4'hf) begin
          busy <= 1'b0;
          spi_done <= 1'b1;
        end
      end else if (!busy) begin
        sck_q <= clock_idle_polarity;
      end
    end
  end

  assign spi_ovf = spi_done & is_spi_slave(mode) & buffer_full_flag;

  // ****************************************
  // I2C slave reception
  // ****************************************
  ssp_i2c_e i2c_st;
  logic [3:0] i2c_cnt;
  logic ack_drv;
  logic i2c_load;
  logic i2c_ovf;
  logic i2c_da;
  logic i2c_rw;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic match;

  assign scl_rise = sck_s & ~s_d[0];
  assign scl_fall = ~sck_s & s_d[0];
  assign start_c = sck_s & s_d[0] & s_d[1] & ~sdi_s;
  assign stop_c = sck_s & s_d[0] & ~s_d[1] & sdi_s;
  assign match = (i2c_sr[7:1] == own_addr) & ~i2c_sr[0];

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      i2c_st <= I2C_IDLE;
      i2c_cnt <= 4'h0;
      i2c_sr <= 8'h0;
      ack_drv <= 1'b0;
      i2c_load <= 1'b0;
      i2c_ovf <= 1'b0;
      i2c_da <= 1'b0;
      i2c_rw <= 1'b0;
    end else begin
      i2c_load <= 1'b0;
      i2c_ovf <= 1'b0;
      if (!en || mode != SSP_M_I2C_SLV) begin
        i2c_st <= I2C_IDLE;
        ack_drv <= 1'b0;
      end else if (start_c) begin
        i2c_st <= I2C_ADDR;
        i2c_cnt <= 4'h0;
        ack_drv <= 1'b0;
      end else if (stop_c) begin
        i2c_st <= I2C_IDLE;
        ack_drv <= 1'b0;
      end else begin
        unique case (i2c_st)
          I2C_IDLE: ;
          I2C_ADDR, I2C_DATA: begin
            if (scl_rise) begin
              i2c_sr <= {i2c_sr[6:0], sdi_s};
              i2c_cnt <= i2c_cnt + 4'd1;
            end else if (scl_fall && i2c_cnt == 4'd8) begin
              i2c_cnt <= 4'h0;
              if (i2c_st == I2C_DATA || match) begin
                i2c_st <= I2C_ACK;
                ack_drv <= ~buffer_full_flag;
                i2c_load <= ~buffer_full_flag;
                i2c_ovf <= buffer_full_flag;
                i2c_da <= (i2c_st == I2C_DATA);
                if (i2c_st == I2C_ADDR) begin
                  i2c_rw <= i2c_sr[0];
                end
              end else begin
                i2c_st <= I2C_IDLE;
              end
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              ack_drv <= 1'b0;
              i2c_st <= I2C_DATA;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Buffer, flags and control register
  // ****************************************
  logic load;
  logic ovf_evt;
  logic write_collision_flag_evt;
  logic byte_evt;
  logic [7:0] next_ctrl;
  logic [2:0] ev;
  logic [2:0] w1c;

  assign load = (spi_done & ~spi_ovf) | i2c_load;
  assign ovf_evt = spi_ovf | i2c_ovf;
  assign write_collision_flag_evt = wr_buf & xfer_busy & (mode != SSP_M_I2C_SLV);
  assign byte_evt = spi_done | i2c_load | i2c_ovf;
  assign ev = {ovf_evt, write_collision_flag_evt, byte_evt};
  assign w1c = (wr && addr_is(PADDR, `SSP_ISTAT_OFS)) ? PWDATA[2:0] : 3'h0;

  always_comb begin
    next_ctrl = port_control_reg;
    if (wr && addr_is(PADDR, `SSP_CTRL_OFS)) begin
      next_ctrl = PWDATA[7:0];
    end
    // A collision or overflow in the same cycle as a clearing write still sticks.
    if (write_collision_flag_evt) begin
      next_ctrl[`SSP_WRITE_COLLISION_FLAG_BIT] = 1'b1;
    end
    if (ovf_evt) begin
      next_ctrl[`SSP_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      port_control_reg <= `SSP_CTRL_RST;
    end else begin
      port_control_reg <= next_ctrl;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      own_addr <= `SSP_OWN_RST;
      imask <= `SSP_IMASK_RST;
    end else if (wr) begin
      if (addr_is(PADDR, `SSP_OWN_OFS)) begin
        own_addr <= PWDATA[6:0];
      end
      if (addr_is(PADDR, `SSP_IMASK_OFS)) begin
        imask <= PWDATA[2:0];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_buffer <= 8'h0;
      buffer_full_flag <= 1'b0;
      st_rw <= 1'b0;
      st_da <= 1'b0;
    end else begin
      if (load) begin
        shift_buffer <= i2c_load ? i2c_sr : shift_register;
        buffer_full_flag <= 1'b1;
      end else if (rd_buf) begin
        buffer_full_flag <= 1'b0;
      end
      if (i2c_load || i2c_ovf) begin
        st_rw <= i2c_rw;
        st_da <= i2c_da;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ists <= 3'h0;
      IRQ <= 1'b0;
    end else begin
      ists <= (ists & ~w1c) | ev;
      IRQ <= |(ists & imask);
    end
  end

  // ****************************************
  // Pin ownership
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCK_OUT <= 1'b0;
      SCK_OE <= 1'b0;
      SDO_OUT <= 1'b0;
      SDO_OE <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      SS_OWNED <= 1'b0;
    end else begin
      SCK_OUT <= sck_q;
      SCK_OE <= en & is_master(mode);
      SDO_OUT <= sdo_q;
      SDO_OE <= en & (is_master(mode) | (is_spi_slave(mode) & slv_sel));
      SDA_OUT <= 1'b0;
      SDA_OE <= en & ack_drv;
      SS_OWNED <= en & (mode == SSP_M_SLV_SS);
    end
  end
endmodule : ssp_top
`default_nettype wire

// ===== verification/ssp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_peer (
  input wire logic clk,
  input wire logic master,
  input wire logic [7:0] tx,
  input wire logic sck_out,
  input wire logic sdo_out,
  input wire logic sda_oe,
  output logic sck_in,
  output logic sdi_in
);
  logic sda_drv = 1'b1;
  logic last_sck = 1'b0;
  logic [7:0] spi_tx = 8'h00;
  logic [7:0] spi_rx = 8'h00;
  int edges = 0;
  initial sck_in = 1'b0;
  // The data line has a pull-up, so it reads low whenever either side pulls it.
  assign sdi_in = master ? spi_tx[7] : (sda_drv && !sda_oe);
  // Bits move on the trailing edge, settling before the next leading edge except at the divide-by-4 rate.
  always @(posedge clk) begin
    last_sck <= sck_out;
    if (!master) begin
      edges <= 0;
      spi_tx <= tx;
    end else if (sck_out != last_sck) begin
      edges <= edges + 1;
      if (edges[0]) begin
        spi_tx <= {spi_tx[6:0], ~spi_tx[0]};
      end else begin
        spi_rx <= {spi_rx[6:0], sdo_out};
      end
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic start;
    sda_drv <= 1'b1;
    wt(6);
    sck_in <= 1'b1;
    wt(6);
    sda_drv <= 1'b0;
    wt(6);
    sck_in <= 1'b0;
    wt(6);
  endtask : start
  task automatic send(input logic [7:0] b, input logic nine, output logic ack);
    ack = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      wt(6);
      sck_in <= 1'b1;
      wt(6);
      sck_in <= 1'b0;
    end
    if (nine) begin
      sda_drv <= 1'b1;
      wt(6);
      sck_in <= 1'b1;
      wt(3);
      ack = sda_oe;
      wt(3);
      sck_in <= 1'b0;
    end
    wt(6);
  endtask : send
endmodule : ssp_peer
`default_nettype wire

// ===== verification/ssp_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_checker (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCK_OUT,
  input wire logic SCK_IN,
  input wire logic SCK_OE,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic SDO_OE,
  input wire logic SS_N_IN,
  input wire logic SS_OWNED
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_deselected;
    (SS_OWNED && SS_N_IN) [*5];
  endsequence
  apb_zero_wait_a: assert property (s_setup |=> PREADY) else $error("ready late");
  ready_single_a: assert property (PREADY |=> !PREADY) else $error("ready held");
  err_in_access_a: assert property (PSLVERR |-> PREADY && PENABLE) else $error("stray error");
  sck_half_a: assert property (SCK_OE && $changed(SCK_OUT) |=> $stable(SCK_OUT))
    else $error("clock too fast");
  sda_open_drain_a: assert property (SDA_OUT == 1'b0) else $error("sda driven high");
  ack_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE [*4]) else $error("ack short");
  ack_scl_low_a: assert property ($rose(SDA_OE) |-> !SCK_IN)
    else $error("ack while clock high");
  slave_clock_a: assert property (SS_OWNED |-> !SCK_OE) else $error("slave drives clock");
  ss_gate_a: assert property (s_deselected |-> !SDO_OE) else $error("unselected drive");
  i2c_pins_a: assert property (SDA_OE |-> !SCK_OE && !SDO_OE) else $error("pin clash");
endmodule : ssp_checker
bind ssp_top ssp_checker u_chk (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .SCK_OUT, .SCK_IN, .SCK_OE, .SDA_OUT, .SDA_OE, .SDO_OE, .SS_N_IN, .SS_OWNED);
`default_nettype wire

// ===== verification/ssp_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sync_serial_port_spi_i2c_rx_tb;
  logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, TIMER_TWO_OUT = 0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic PREADY, PSLVERR, IRQ, SCK_IN, SCK_OUT, SCK_OE, SDI_IN, SDO_OUT, SDO_OE;
  logic SDA_OUT, SDA_OE, SS_OWNED, err, ack, master = 0, SS_N_IN = 1;
  logic [7:0] tx = 8'h3c;
  int n_fail = 0, checks_done = 0, k, h;
  int half [4] = '{2, 8, 32, 10};
  ssp_top dut (.REF_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .IRQ, .SCK_IN, .SCK_OUT, .SCK_OE, .SDI_IN, .SDO_OUT, .SDO_OE,
    .SDA_OUT, .SDA_OE, .SS_N_IN, .SS_OWNED, .TIMER_TWO_OUT);
  ssp_peer peer (.clk(REF_CLK), .master, .tx, .sck_out(SCK_OUT), .sda_oe(SDA_OE),
    .sdo_out(SDO_OUT), .sck_in(SCK_IN), .sdi_in(SDI_IN));
  always #25 REF_CLK = ~REF_CLK;
  always begin
    repeat (5) @(posedge REF_CLK);
    TIMER_TWO_OUT <= ~TIMER_TWO_OUT;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1;
    // Only PREADY or the watchdog ends a wait for the answer.
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task automatic wt(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : wt
  initial begin
    #(20000 * 50);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    wt(20);
    RST_N <= 1;
    apb(0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(0, 12'h018, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h00c, 32'h7);
      apb(1, 12'h000, 32'h20 | m);
      master <= 0;
      wt(4);
      master <= 1;
      wt(8);
      chk("edges before write", 0, peer.edges);
      apb(1, 12'h004, 32'ha5);
      apb(1, 12'h004, 32'h5a);
      for (k = 0; k < 900 && peer.edges < 2; k++) @(posedge REF_CLK);
      for (h = 0; h < 900 && peer.edges < 3; h++) @(posedge REF_CLK);
      chk("sck half period", half[m], h);
      for (k = 0; k < 1500 && peer.edges < 16; k++) @(posedge REF_CLK);
      wt(8);
      chk("master tx", 32'ha5, peer.spi_rx);
      apb(0, 12'h000, 32'h0);
      chk("ctrl flags", 32'ha0 | m, rd);
      apb(0, 12'h00c, 32'h0);
      chk("event status", 32'h3, rd);
      if (m > 0) begin
        apb(0, 12'h004, 32'h0);
        chk("master rx", 32'h3c, rd);
      end
    end
    master <= 0;
    apb(1, 12'h000, 32'h30);
    wt(4);
    chk("sck idle high", 32'h3, {SCK_OUT, SCK_OE});
    apb(1, 12'h000, 32'h10);
    wt(4);
    chk("pins released", 32'h0, {SCK_OE, SDO_OE});
    apb(1, 12'h00c, 32'h7);
    apb(1, 12'h010, 32'h1);
    apb(1, 12'h000, 32'h24);
    wt(2);
    chk("select owned", 32'h1, SS_OWNED);
    chk("slave pin dirs", 32'h0, {SCK_OE, SDO_OE});
    peer.send(8'h5a, 0, ack);
    apb(0, 12'h00c, 32'h0);
    chk("gated byte", 32'h0, rd);
    SS_N_IN <= 0;
    wt(4);
    peer.send(8'h5a, 0, ack);
    wt(6);
    chk("irq raised", 32'h1, IRQ);
    apb(0, 12'h004, 32'h0);
    chk("slave rx", 32'h5a, rd);
    peer.send(8'hc3, 0, ack);
    peer.send(8'h11, 0, ack);
    wt(6);
    apb(0, 12'h000, 32'h0);
    chk("overflow", 32'h64, rd);
    apb(0, 12'h004, 32'h0);
    chk("kept byte", 32'hc3, rd);
    apb(1, 12'h010, 32'h0);
    wt(2);
    chk("irq masked", 32'h0, IRQ);
    apb(1, 12'h010, 32'h1);
    apb(1, 12'h00c, 32'h7);
    wt(2);
    chk("irq cleared", 32'h0, IRQ);
    apb(1, 12'h000, 32'h25);
    SS_N_IN <= 1;
    wt(4);
    chk("select free", 32'h0, SS_OWNED);
    peer.send(8'h3c, 0, ack);
    wt(6);
    apb(0, 12'h004, 32'h0);
    chk("unselected rx", 32'h3c, rd);
    apb(1, 12'h014, 32'h2a);
    apb(1, 12'h000, 32'h26);
    apb(1, 12'h00c, 32'h7);
    peer.start();
    peer.send(8'h56, 1, ack);
    chk("foreign address", 32'h0, ack);
    peer.start();
    peer.send(8'h54, 1, ack);
    chk("address ack", 32'h1, ack);
    apb(0, 12'h008, 32'h0);
    chk("address status", 32'h1, rd);
    peer.send(8'h99, 1, ack);
    chk("full nack", 32'h0, ack);
    apb(0, 12'h000, 32'h0);
    chk("address overflow", 32'h66, rd);
    apb(0, 12'h004, 32'h0);
    chk("loaded address", 32'h54, rd);
    apb(1, 12'h000, 32'h26);
    peer.start();
    peer.send(8'h54, 1, ack);
    apb(0, 12'h004, 32'h0);
    apb(1, 12'h00c, 32'h7);
    peer.send(8'h77, 1, ack);
    chk("data ack", 32'h1, ack);
    apb(0, 12'h008, 32'h0);
    chk("data status", 32'h5, rd);
    apb(0, 12'h00c, 32'h0);
    chk("byte event", 32'h1, rd);
    apb(0, 12'h004, 32'h0);
    chk("data byte", 32'h77, rd);
    tally_and_finish();
  end
endmodule : sync_serial_port_spi_i2c_rx_tb
`default_nettype wire
